/* src/sram_port_pkg.sv */
package sram_port_pkg;

    // Array geometry: 256K words, two lanes of eight data bits plus parity
    localparam int ADDR_W    = 18;
    localparam int LANES     = 2;
    localparam int LANE_DQ_W = 8;
    localparam int LANE_W    = LANE_DQ_W + 1;
    localparam int DQ_W      = LANES * LANE_DQ_W;
    localparam int WORD_W    = LANES * LANE_W;
    localparam int BEAT_W    = 2;
    localparam int FIFO_DEPTH = 16;

    localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
    localparam logic [BEAT_W-1:0] BEAT_STEP  = 2'h1;
    localparam logic [LANES-1:0]  LANES_NONE = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_ZERO  = 18'h0_0000;
    localparam logic [WORD_W-1:0] WORD_ZERO  = 18'h0_0000;

    typedef enum logic {
        BURST_LINEAR,
        BURST_INTERLEAVED
    } burst_order_t;

    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_READ,
        ACC_WRITE
    } acc_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  lane_en;
        logic [WORD_W-1:0] data;
    } wr_req_t;

    localparam int WR_REQ_W = $bits(wr_req_t);

endpackage

/* src/sync_fifo.sv */
`timescale 1ns/100ps
module sync_fifo #(
    parameter int WIDTH = 38,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk_in,  // Clock
    input  wire logic             rst_b_in,     // Async reset, low
    input  wire logic             in_valid_in,  // Push request
    output logic                  in_ready_out, // Not full
    input  wire logic [WIDTH-1:0] in_data_in,   // Push data
    output logic                  out_valid_out,// Not empty
    input  wire logic             out_ready_in, // Pop request
    output logic [WIDTH-1:0]      out_data_out  // Head entry
);
    localparam int PTR_W = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
        $error("sync_fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] slot_reg [DEPTH];
    logic [PTR_W:0]   wr_ptr_reg;
    logic [PTR_W:0]   rd_ptr_reg;
    wire              push = in_valid_in & in_ready_out;
    wire              pop  = out_ready_in & out_valid_out;
    wire              ptr_same =
        wr_ptr_reg[PTR_W-1:0] == rd_ptr_reg[PTR_W-1:0];

    assign out_valid_out = wr_ptr_reg != rd_ptr_reg;
    assign in_ready_out  = !(ptr_same &&
                             wr_ptr_reg[PTR_W] != rd_ptr_reg[PTR_W]);
    assign out_data_out  = slot_reg[rd_ptr_reg[PTR_W-1:0]];

    always_ff @(posedge core_clk_in) begin
        if (push) begin
            slot_reg[wr_ptr_reg[PTR_W-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + (PTR_W+1)'(push);
            rd_ptr_reg <= rd_ptr_reg + (PTR_W+1)'(pop);
        end
    end
endmodule

/* src/sync_flowthrough_burst_sram_port.sv */
`timescale 1ns/100ps
module sync_flowthrough_burst_sram_port
    import sram_port_pkg::*;
#(
    parameter int ADDR_BITS  = ADDR_W,
    parameter int BUF_DEPTH  = FIFO_DEPTH
) (
    input  wire logic              core_clk_in,             // Clock
    input  wire logic              rst_b_in,                // Reset, low
    input  wire logic [ADDR_W-1:0] addr_in,                 // Word address
    input  wire logic              chip_select_first_n_in,  // Select, low
    input  wire logic              chip_select_second_in,   // Select, high
    input  wire logic              chip_select_third_n_in,  // Select, low
    input  wire logic              write_strobe_n_in,       // Write, low
    input  wire logic [LANES-1:0]  lane_write_select_n_in,  // Lanes, low
    input  wire logic              advance_or_load_in,      // 1 step, 0 load
    input  wire logic              clock_qualify_n_in,      // Edge ok, low
    input  wire logic              output_enable_n_in,      // Drive ok, low
    input  wire logic              burst_order_in,          // 1 interleaved
    input  wire logic              sleep_request_in,        // Sleep, high
    input  wire logic [DQ_W-1:0]   dq_in,                   // Data lines in
    output logic [DQ_W-1:0]        dq_out,                  // Data lines out
    output logic                   dq_oe_n_out,             // Drive, low
    input  wire logic [LANES-1:0]  lane_parity_lines_in,    // Parity in
    output logic [LANES-1:0]       lane_parity_lines_out,   // Parity out
    output logic                   lane_parity_lines_oe_n_out, // Drive, low
    output logic                   write_buffer_ready_out,  // Buffer room
    output logic                   sleep_active_out         // Asleep
);
    if (ADDR_BITS != ADDR_W || BUF_DEPTH < 2) begin : g_bad_param
        $error("port serves only the fixed array and a buffer of 2 or more");
    end

    // Burst address step, shared by the read and write paths
    function automatic logic [BEAT_W-1:0] burst_low(
        input logic [BEAT_W-1:0] seed,
        input logic [BEAT_W-1:0] beat,
        input burst_order_t      order
    );
        burst_low = (order == BURST_INTERLEAVED) ? (seed ^ beat) :
                    (seed + beat);
    endfunction

    // Lane bits of a word: parity sits on top of its data byte
    function automatic logic [WORD_W-1:0] pack_word(
        input logic [DQ_W-1:0]  dq,
        input logic [LANES-1:0] par
    );
        for (int l = 0; l < LANES; l++) begin
            pack_word[l*LANE_W +: LANE_W] =
                {par[l], dq[l*LANE_DQ_W +: LANE_DQ_W]};
        end
    endfunction

    acc_state_t        state_reg;
    acc_state_t        state_next;
    logic [ADDR_W-1:0] seed_reg;
    logic [ADDR_W-1:0] seed_next;
    logic [BEAT_W-1:0] beat_reg;
    logic [BEAT_W-1:0] beat_next;
    logic              wphase_reg;
    logic              wphase_next;
    logic [ADDR_W-1:0] waddr_reg;
    logic [ADDR_W-1:0] waddr_next;
    logic [LANES-1:0]  wlane_reg;
    logic [LANES-1:0]  wlane_next;
    logic              drive_reg;
    logic              drive_next;
    logic              sleep_reg;
    logic              buf_ready_reg;
    burst_order_t      order_reg;
    logic              strap_taken_reg;

    logic              fifo_in_ready;
    logic              fifo_out_valid;
    wr_req_t           fifo_head;
    logic [WORD_W-1:0] rd_word;

    // Qualified edge: with qualify high no access or write capture moves; the buffer still drains
    wire qual      = !clock_qualify_n_in;
    wire awake     = !sleep_reg;
    wire selected  = !chip_select_first_n_in && chip_select_second_in &&
                     !chip_select_third_n_in;
    wire start     = qual && awake && !advance_or_load_in && selected;
    wire deselect  = qual && ((!advance_or_load_in && !selected) ||
                     sleep_reg);
    // Continue cycles look at neither selects nor strobe
    wire advance   = qual && awake && advance_or_load_in &&
                     state_reg != ACC_IDLE;

    wire [BEAT_W-1:0] beat_step = beat_reg + BEAT_STEP;
    wire [ADDR_W-1:0] burst_addr = {seed_reg[ADDR_W-1:BEAT_W],
        burst_low(seed_reg[BEAT_W-1:0], beat_step, order_reg)};
    wire [ADDR_W-1:0] access_addr = start ? addr_in : burst_addr;
    wire access_edge  = start || advance;
    wire access_read  = start ? write_strobe_n_in :
                        (state_reg == ACC_READ);
    wire read_fire    = access_edge && access_read;
    wire write_fire   = access_edge && !access_read;

    // Write data phase: data arrives on the edge after the address
    wire     capture   = qual && wphase_reg;
    wire     abort     = wlane_reg == LANES_NONE;
    wr_req_t capt_req;
    assign capt_req.addr    = waddr_reg;
    assign capt_req.lane_en = wlane_reg;
    assign capt_req.data    = pack_word(dq_in, lane_parity_lines_in);

    // Buffer only holds writes while the array is asleep or backlogged,
    // so normal writes reach the array on their own edge
    wire wr_keep    = capture && !abort;
    wire pop        = fifo_out_valid && awake;
    wire direct_wr  = wr_keep && !fifo_out_valid && awake;
    wire push       = wr_keep && !direct_wr;
    wire store_we   = pop || direct_wr;
    wr_req_t store_req;
    assign store_req = pop ? fifo_head : capt_req;

    always_comb begin
        state_next = state_reg;
        if (start) begin
            state_next = write_strobe_n_in ? ACC_READ : ACC_WRITE;
        end else if (deselect) begin
            state_next = ACC_IDLE;
        end
    end

    // Qualify high alone leaves state_reg untouched, never idles it
    always_comb begin
        seed_next = seed_reg;
        beat_next = beat_reg;
        if (start) begin
            seed_next = addr_in;
            beat_next = BEAT_FIRST;
        end else if (advance) begin
            beat_next = beat_step;
        end
    end

    always_comb begin
        wphase_next = wphase_reg;
        waddr_next  = waddr_reg;
        wlane_next  = wlane_reg;
        if (qual) begin
            wphase_next = write_fire;
        end
        if (write_fire) begin
            waddr_next = access_addr;
            wlane_next = ~lane_write_select_n_in;
        end
    end

    // Lines drive only in a read cycle; writes, deselect and sleep
    // all leave drive_reg low
    always_comb begin
        drive_next = drive_reg && awake;
        if (qual) begin
            drive_next = read_fire;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg <= ACC_IDLE;
            seed_reg  <= ADDR_ZERO;
            beat_reg  <= BEAT_FIRST;
        end else begin
            state_reg <= state_next;
            seed_reg  <= seed_next;
            beat_reg  <= beat_next;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wphase_reg <= 1'b0;
            waddr_reg  <= ADDR_ZERO;
            wlane_reg  <= LANES_NONE;
            drive_reg  <= 1'b0;
        end else begin
            wphase_reg <= wphase_next;
            waddr_reg  <= waddr_next;
            wlane_reg  <= wlane_next;
            drive_reg  <= drive_next;
        end
    end

    // Sleep is sampled each edge; it idles the port and stalls draining
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sleep_reg     <= 1'b0;
            buf_ready_reg <= 1'b0;
        end else begin
            sleep_reg     <= sleep_request_in;
            buf_ready_reg <= fifo_in_ready;
        end
    end

    // Strap taken once after reset release; a strap must not move later
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            order_reg       <= BURST_INTERLEAVED;
            strap_taken_reg <= 1'b0;
        end else if (!strap_taken_reg) begin
            order_reg       <= burst_order_in ? BURST_INTERLEAVED :
                               BURST_LINEAR;
            strap_taken_reg <= 1'b1;
        end
    end

    sync_fifo #(
        .WIDTH (WR_REQ_W),
        .DEPTH (BUF_DEPTH)
    ) u_write_buffer (
        .core_clk_in   (core_clk_in),
        .rst_b_in      (rst_b_in),
        .in_valid_in   (push),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (capt_req),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (pop),
        .out_data_out  (fifo_head)
    );

    word_store #(
        .ADDR_W (ADDR_W),
        .LANES  (LANES),
        .LANE_W (LANE_W)
    ) u_array (
        .core_clk_in (core_clk_in),
        .rst_b_in    (rst_b_in),
        .wr_en_in    (store_we),
        .wr_addr_in  (store_req.addr),
        .wr_lane_in  (store_req.lane_en),
        .wr_data_in  (store_req.data),
        .rd_en_in    (read_fire && awake),
        .rd_addr_in  (access_addr),
        .rd_data_out (rd_word)
    );

    // Read word register feeds the lines directly, no output stage
    for (genvar l = 0; l < LANES; l++) begin : g_out_lane
        assign dq_out[l*LANE_DQ_W +: LANE_DQ_W] =
            rd_word[l*LANE_W +: LANE_DQ_W];
        assign lane_parity_lines_out[l] =
            rd_word[l*LANE_W + LANE_DQ_W];
    end

    // Output enable acts without the clock, as does sleep on the lines
    wire float_lines = output_enable_n_in || !drive_reg ||
                       sleep_request_in;
    assign dq_oe_n_out                = float_lines;
    assign lane_parity_lines_oe_n_out = float_lines;
    assign write_buffer_ready_out     = buf_ready_reg;
    assign sleep_active_out           = sleep_reg;
endmodule

/* src/word_store.sv */
`timescale 1ns/100ps
module word_store #(
    parameter int ADDR_W = 18,
    parameter int LANES  = 2,
    parameter int LANE_W = 9
) (
    input  wire logic                     core_clk_in,  // Clock
    input  wire logic                     rst_b_in,     // Async reset, low
    input  wire logic                     wr_en_in,     // Write this edge
    input  wire logic [ADDR_W-1:0]        wr_addr_in,   // Write address
    input  wire logic [LANES-1:0]         wr_lane_in,   // Lane enables
    input  wire logic [LANES*LANE_W-1:0]  wr_data_in,   // Write word
    input  wire logic                     rd_en_in,     // Read this edge
    input  wire logic [ADDR_W-1:0]        rd_addr_in,   // Read address
    output logic [LANES*LANE_W-1:0]       rd_data_out   // Registered word
);
    if (ADDR_W < 2 || LANES < 1 || LANE_W < 1) begin : g_bad_shape
        $error("word_store needs two address bits and one lane");
    end

    logic [LANES*LANE_W-1:0] cell_reg [2**ADDR_W];
    logic [LANES*LANE_W-1:0] rd_data_reg;
    logic [LANES*LANE_W-1:0] rd_merge;
    wire  [LANES*LANE_W-1:0] old_word = cell_reg[rd_addr_in];
    wire                     collide  = wr_en_in && wr_addr_in == rd_addr_in;

    // Same-edge write wins per lane, so a read right behind a write is fresh
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        assign rd_merge[l*LANE_W +: LANE_W] = (collide && wr_lane_in[l]) ?
            wr_data_in[l*LANE_W +: LANE_W] : old_word[l*LANE_W +: LANE_W];
    end

    always_ff @(posedge core_clk_in) begin
        if (wr_en_in) begin
            for (int l = 0; l < LANES; l++) begin
                if (wr_lane_in[l]) begin
                    cell_reg[wr_addr_in][l*LANE_W +: LANE_W] <=
                        wr_data_in[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_data_reg <= '0;
        end else if (rd_en_in) begin
            rd_data_reg <= rd_merge;
        end
    end

    assign rd_data_out = rd_data_reg;
endmodule

/* test/sram_ctrl_model.sv */
`timescale 1ns/100ps
module sram_ctrl_model
    import sram_port_pkg::*;
(
    input  wire logic             clk_in, // Clock
    input  wire logic [DQ_W-1:0]  dq_dut_in, // Device data
    input  wire logic [LANES-1:0] par_dut_in, // Device parity
    input  wire logic             oe_dut_n_in, // Device drives, low
    output logic [ADDR_W-1:0]     addr_out, // Address
    output logic                  chip_select_first_n_out, // Select
    output logic                  chip_select_second_out, // Select
    output logic                  chip_select_third_n_out, // Select
    output logic                  write_strobe_n_out, // Write, low
    output logic [LANES-1:0]      lane_write_select_n_out, // Lanes
    output logic                  advance_or_load_out, // Step
    output logic                  clock_qualify_n_out, // Qualify
    output logic [DQ_W-1:0]       dq_bus_out, // Resolved data
    output logic [LANES-1:0]      lane_parity_lines_out // Resolved parity
);
    logic [WORD_W-1:0] owed_word = WORD_ZERO;
    logic              owed      = 1'b0;
    logic [WORD_W-1:0] pend_word = WORD_ZERO;
    logic              pend      = 1'b0;
    logic              burst_wr  = 1'b0;
    logic [WORD_W-1:0] last_word = WORD_ZERO;
    logic [WORD_W-1:0] bus_word;

    // Nobody driving: lines wander, so a stale value can never pass
    assign bus_word = owed ? owed_word : !oe_dut_n_in ?
        {par_dut_in[1], dq_dut_in[15:8], par_dut_in[0], dq_dut_in[7:0]} :
        ~last_word;
    assign dq_bus_out = {bus_word[16:9], bus_word[7:0]};
    assign lane_parity_lines_out = {bus_word[17], bus_word[8]};
    always @(posedge clk_in) last_word <= bus_word;

    initial begin
        addr_out = ADDR_ZERO;
        chip_select_first_n_out = 1'b1;
        chip_select_second_out = 1'b0;
        chip_select_third_n_out = 1'b1;
        write_strobe_n_out = 1'b1;
        lane_write_select_n_out = 2'h3;
        advance_or_load_out = 1'b0;
        clock_qualify_n_out = 1'b0;
    end

    // op: 0 deselect, 1 read start, 2 write start, 3 continue, 4 stall
    task automatic cycle(input int op, input logic [ADDR_W-1:0] a,
                         input logic [LANES-1:0] ln_n,
                         input logic [WORD_W-1:0] wd);
        @(posedge clk_in);
        clock_qualify_n_out <= (op == 4);
        if (op != 4) begin
            owed <= pend;
            owed_word <= pend_word;
            if (op == 1 || op == 2) burst_wr = (op == 2);
            if (op == 0) burst_wr = 1'b0;
            pend = (op == 2) || (op == 3 && burst_wr);
            pend_word = wd;
            addr_out <= a;
            advance_or_load_out <= (op == 3);
            // Continue beats carry junk selects and strobe on purpose
            chip_select_first_n_out <= (op == 3) ? a[0] : (op == 0);
            chip_select_second_out <= (op == 3) ? a[1] : 1'b1;
            chip_select_third_n_out <= (op == 3) ? a[2] : 1'b0;
            write_strobe_n_out <= (op == 3) ? a[3] : (op != 2);
            lane_write_select_n_out <= ln_n;
        end
    endtask
endmodule

/* test/sram_port_asserts.sv */
`timescale 1ns/100ps
module sram_port_asserts
    import sram_port_pkg::*;
#(
    parameter int ADDR_BITS = ADDR_W,
    parameter int BUF_DEPTH = FIFO_DEPTH
) (
    input wire logic             core_clk_in, // Clock
    input wire logic             rst_b_in, // Reset, low
    input wire logic             chip_select_first_n_in, // Select
    input wire logic             chip_select_second_in, // Select
    input wire logic             chip_select_third_n_in, // Select
    input wire logic             write_strobe_n_in, // Write, low
    input wire logic             advance_or_load_in, // Step
    input wire logic             clock_qualify_n_in, // Qualify
    input wire logic             output_enable_n_in, // Drive ok
    input wire logic             sleep_request_in, // Sleep
    input wire logic [DQ_W-1:0]  dq_out, // Read data
    input wire logic             dq_oe_n_out, // Drive, low
    input wire logic [LANES-1:0] lane_parity_lines_out, // Parity
    input wire logic             lane_parity_lines_oe_n_out, // Drive
    input wire logic             write_buffer_ready_out, // Room
    input wire logic             sleep_active_out // Asleep
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    logic sel_on;
    logic edge_ok;
    assign sel_on = !chip_select_first_n_in && chip_select_second_in &&
                    !chip_select_third_n_in;
    assign edge_ok = !clock_qualify_n_in && !sleep_request_in &&
                     !sleep_active_out;

    sequence s_start;
        edge_ok && sel_on && !advance_or_load_in;
    endsequence
    sequence s_read;
        s_start ##0 write_strobe_n_in;
    endsequence
    sequence s_may_drive;
        !output_enable_n_in && !sleep_request_in;
    endsequence

    a_stall_holds_data: assert property (
        clock_qualify_n_in |=> $stable(dq_out) &&
        $stable(lane_parity_lines_out)) else $error("stall moved data");
    a_stall_keeps_drive: assert property (
        clock_qualify_n_in && !dq_oe_n_out ##1 s_may_drive |-> !dq_oe_n_out)
        else $error("stall dropped the drive");
    a_oe_floats_lines: assert property (
        output_enable_n_in |-> dq_oe_n_out) else $error("drove with oe high");
    a_sleep_floats_lines: assert property (
        sleep_request_in |-> dq_oe_n_out && lane_parity_lines_oe_n_out)
        else $error("drove while asleep");
    a_parity_oe_pairs: assert property (
        dq_oe_n_out == lane_parity_lines_oe_n_out)
        else $error("parity drive differs");
    a_write_data_floats: assert property (
        s_start ##0 !write_strobe_n_in |=> dq_oe_n_out)
        else $error("drove in write data phase");
    a_deselect_floats: assert property (
        edge_ok && !advance_or_load_in && !sel_on |=> dq_oe_n_out)
        else $error("drove while deselected");
    a_read_drives_word: assert property (
        s_read ##1 s_may_drive |-> !dq_oe_n_out)
        else $error("read not driven");
    a_continue_drives: assert property (
        s_read ##1 (!clock_qualify_n_in && advance_or_load_in)
        ##1 s_may_drive |-> !dq_oe_n_out) else $error("continue not driven");
    a_sleep_flag_follows: assert property (
        !clock_qualify_n_in && sleep_request_in |=> sleep_active_out)
        else $error("sleep flag missing");
    a_ready_after_reset: assert property (
        $rose(rst_b_in) |=> write_buffer_ready_out)
        else $error("buffer not ready");
endmodule

bind sync_flowthrough_burst_sram_port sram_port_asserts #(
    .ADDR_BITS(ADDR_BITS),
    .BUF_DEPTH(BUF_DEPTH)
) u_chk (.*);

/* test/tb.sv */
`timescale 1ns/100ps
`define CHECK(got, want) \
    begin \
        samples_checked++; \
        if ((got) !== (want)) begin \
            err_total++; \
            $display("FAIL %0t got %h want %h", $time, got, want); \
        end \
    end
module tb;
    import sram_port_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic oe_n = 1'b0;
    logic sleep = 1'b0;
    logic strap = 1'b0;
    integer seed = 32'h0000_396b;
    int err_total = 0;
    int samples_checked = 0;
    logic [WORD_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [WORD_W-1:0] exp_q [$];
    logic [ADDR_W-1:0] addr;
    logic cs1_n, cs2, cs3_n, we_n, adv, qn, dqoen, paroen, rdy, slp;
    logic [LANES-1:0] ln_n, pari, paro;
    logic [DQ_W-1:0] dqi, dqo;

    initial begin
        forever #50 clk = ~clk;
    end

    sync_flowthrough_burst_sram_port dut (
        .core_clk_in(clk), .rst_b_in(rst_b), .addr_in(addr),
        .chip_select_first_n_in(cs1_n), .chip_select_second_in(cs2),
        .chip_select_third_n_in(cs3_n), .write_strobe_n_in(we_n),
        .lane_write_select_n_in(ln_n), .advance_or_load_in(adv),
        .clock_qualify_n_in(qn), .output_enable_n_in(oe_n),
        .burst_order_in(strap), .sleep_request_in(sleep), .dq_in(dqi),
        .dq_out(dqo), .dq_oe_n_out(dqoen), .lane_parity_lines_in(pari),
        .lane_parity_lines_out(paro), .lane_parity_lines_oe_n_out(paroen),
        .write_buffer_ready_out(rdy), .sleep_active_out(slp));

    sram_ctrl_model ctrl (
        .clk_in(clk), .dq_dut_in(dqo), .par_dut_in(paro),
        .oe_dut_n_in(dqoen), .addr_out(addr),
        .chip_select_first_n_out(cs1_n), .chip_select_second_out(cs2),
        .chip_select_third_n_out(cs3_n), .write_strobe_n_out(we_n),
        .lane_write_select_n_out(ln_n), .advance_or_load_out(adv),
        .clock_qualify_n_out(qn), .dq_bus_out(dqi),
        .lane_parity_lines_out(pari));

    function automatic logic [1:0] beat_lo(logic [1:0] s, int k);
        return strap ? s ^ 2'(k) : s + 2'(k);
    endfunction

    function automatic logic [WORD_W-1:0] merge(logic [WORD_W-1:0] old,
        logic [WORD_W-1:0] nw, logic [LANES-1:0] sel_n);
        merge = old;
        if (!sel_n[0]) merge[8:0] = nw[8:0];
        if (!sel_n[1]) merge[17:9] = nw[17:9];
    endfunction

    task automatic idle();
        ctrl.cycle(0, ADDR_ZERO, 2'h3, WORD_ZERO);
    endtask

    // Expected words are noted when the beat is issued
    task automatic burst(input bit wr, input logic [ADDR_W-1:0] a,
                         input int beats, input logic [LANES-1:0] sel_n,
                         input int stall_at);
        logic [ADDR_W-1:0] ba;
        logic [WORD_W-1:0] wd;
        for (int k = 0; k < beats; k++) begin
            if (k == stall_at) ctrl.cycle(4, a, sel_n, wd);
            ba = {a[ADDR_W-1:2], beat_lo(a[1:0], k)};
            wd = WORD_W'($random(seed));
            if (wr) mem[ba] = merge(mem[ba], wd, sel_n);
            if (!wr && !oe_n) exp_q.push_back(mem[ba]);
            ctrl.cycle(k == 0 ? (wr ? 2 : 1) : 3,
                       k == 0 ? a : ADDR_W'($random(seed)), sel_n, wd);
        end
    endtask

    task automatic reset_dut(input logic order);
        rst_b <= 1'b0;
        strap <= order;
        repeat (6) @(posedge clk);
        `CHECK(dqoen, 1'b1)
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    task automatic final_report();
        if (exp_q.size() != 0) begin
            err_total++;
            $display("FAIL %0t reads never answered", $time);
        end
        $display("Compared %0d, mismatched %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        logic q;
        logic [WORD_W-1:0] w;
        forever begin
            @(posedge clk);
            q = qn;
            @(negedge clk);
            if (q === 1'b0 && dqoen === 1'b0) begin
                if (exp_q.size() == 0) begin
                    err_total++;
                    $display("FAIL %0t drive with no read", $time);
                end else begin
                    w = exp_q.pop_front();
                    `CHECK({paro[1], dqo[15:8], paro[0], dqo[7:0]}, w)
                end
            end
        end
    end

    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        $display("FAIL %0t watchdog expired", $time);
        final_report();
    end

    initial begin
        logic [ADDR_W-1:0] blk;
        for (int o = 0; o < 2; o++) begin
            reset_dut(o[0]);
            `CHECK(rdy, 1'b1)
            for (int s = 0; s < 4; s++) begin
                blk = ADDR_W'($random(seed)) & 18'h3_fffc;
                if (s == 0) blk = 18'h3_fffc;
                burst(1, blk | ADDR_W'(s), 4, 2'h0, s + 1);
                burst(0, blk | ADDR_W'(s), 5, 2'h0, 2);
                for (int b = 1; b < 4; b++) begin
                    burst(1, blk, 1, 2'(b), 9);
                    burst(0, blk, 1, 2'h0, 9);
                end
                idle();
                ctrl.cycle(3, blk, 2'h0, WORD_ZERO);
                idle();
            end
            oe_n <= 1'b1;
            idle();
            burst(0, blk, 2, 2'h0, 9);
            idle();
            idle();
            oe_n <= 1'b0;
            // Sleep lands between address and data, so the word is buffered
            burst(1, blk, 1, 2'h0, 9);
            sleep <= 1'b1;
            idle();
            repeat (2) @(posedge clk);
            `CHECK(slp, 1'b1)
            sleep <= 1'b0;
            repeat (3) @(posedge clk);
            burst(0, blk, 1, 2'h0, 9);
            idle();
            idle();
        end
        final_report();
    end
endmodule
